//--- hbp_pkg.sv
// Purpose: shared constants and types for the parallel host port
// Assumes: 50 MHz clk_i, all pins synchronous to it
// Notes: bus lines are split into in/out/enable; the interface resolves them
package hbp_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int CLK_HZ = 50_000_000;
    // reset hold: four serial clock periods at the slowest 512 kHz serial clock
    localparam int SER_CLK_HZ = 512_000;
    localparam int RST_SER_PERIODS = 4;
    localparam int RST_HOLD_CYC = (RST_SER_PERIODS * CLK_HZ + SER_CLK_HZ - 1) / SER_CLK_HZ;
    // device driven reset pulse uses the same length
    localparam int RST_OUT_CYC = RST_HOLD_CYC;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] RST_HOLD_CNT = CNT_W'(RST_HOLD_CYC);
    localparam logic [CNT_W-1:0] RST_OUT_CNT = CNT_W'(RST_OUT_CYC);
    localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam int REGS = 64;
    typedef enum logic {
        STYLE_STROBE_DIR,
        STYLE_SPLIT_RW
    } bus_style_t;
    typedef enum {
        H_IDLE,
        H_ADDR,
        H_SETUP,
        H_STROBE,
        H_END,
        H_RESET
    } host_state_t;
endpackage : hbp_pkg

//--- hbp_if.sv
// Purpose: pins between host and device end
// Assumes: one clock for both parties
// Notes: open-drain and three-state lines resolved here
`timescale 1ns/10ps
interface hbp_if
    import hbp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i
);
    logic [DATA_W-1:0] bus_h_out;
    logic bus_h_oe;
    logic [DATA_W-1:0] bus_d_out;
    logic bus_d_oe;
    logic [DATA_W-1:0] shared_bus_line;
    logic [ADDR_W-1:0] addr_bit_in;
    logic cs_n;
    logic ale;
    logic rw_wr;
    logic access_strobe;
    logic int_d_oe;
    logic irq_n;
    logic rst_h_out;
    logic rst_h_oe;
    logic rst_d_out;
    logic rst_d_oe;
    logic rst_line;
    // pull-up idle level when nobody drives
    assign shared_bus_line = bus_d_oe ? bus_d_out : (bus_h_oe ? bus_h_out : 8'hFF);
    assign irq_n = ~int_d_oe;
    assign rst_line = (rst_h_oe & rst_h_out) | (rst_d_oe & rst_d_out);
    modport dev (
        input clk_i, arst_n_i, shared_bus_line, addr_bit_in, cs_n, ale, rw_wr,
        input access_strobe, rst_line,
        output bus_d_out, bus_d_oe, int_d_oe, rst_d_out, rst_d_oe
    );
    modport host (
        input clk_i, arst_n_i, shared_bus_line, irq_n, rst_line,
        output bus_h_out, bus_h_oe, addr_bit_in, cs_n, ale, rw_wr, access_strobe,
        output rst_h_out, rst_h_oe
    );
endinterface : hbp_if

//--- hbp_edge_det.sv
// Purpose: registered falling and rising edge detect
// Assumes: input already synchronous to clk_i
// Notes: reset level is high, so an input low at release reads as a fall
`timescale 1ns/10ps
module hbp_edge_det (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic sig_i,
    output logic rise_o,
    output logic fall_o
);
    logic prev;
    logic next_prev;
    always_comb begin
        next_prev = sig_i;
        rise_o = sig_i & ~prev;
        fall_o = ~sig_i & prev;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev <= 1'b1;
        end else begin
            prev <= next_prev;
        end
    end
endmodule : hbp_edge_det

//--- hbp_device.sv
// Purpose: device end of the 8-bit parallel host port with a register array
// Assumes: host pins synchronous to clk_i; mode fixed per access
// Notes: user side sees write pulses, pending and reset state, and raises interrupts
`timescale 1ns/10ps
// Operation
// - muxed mode: address then data, shared lines
// - non-muxed mode: shared lines carry data only
// - access only while chip select low
// - direction high read, low write
// - strobe rising edge ends access, captures write
// - split style: read and write strobes
// - interrupt output open drain, low when pending
// - address latch activity selects muxed mode
// - reset high held four serial periods
// - device may drive reset pulse out
// - non-muxed address on six address inputs
// - wake falling edge interrupts, optional reset
module hbp_device
    import hbp_pkg::*;
(
    hbp_if.dev bus,
    input wire logic bus_style_i,
    input wire logic term_fn_en_i,
    input wire logic wake_rst_en_i,
    input wire logic external_wake_i,
    input wire logic irq_set_i,
    input wire logic irq_clr_i,
    output logic wr_pulse_o,
    output logic [ADDR_W-1:0] wr_addr_o,
    output logic [DATA_W-1:0] wr_data_o,
    output logic irq_pend_o,
    output logic dev_in_reset_o
);
    logic [DATA_W-1:0] regs [REGS];
    logic [ADDR_W-1:0] lat_addr, next_lat_addr;
    logic muxed, next_muxed;
    logic irq, next_irq;
    logic wake_irq, next_wake_irq;
    logic [CNT_W-1:0] rst_in_cnt, next_rst_in_cnt;
    logic [CNT_W-1:0] rst_out_cnt, next_rst_out_cnt;
    logic in_reset, next_in_reset;
    logic [DATA_W-1:0] dout, next_dout;
    logic doe, next_doe;
    logic wr_p, next_wr_p;
    logic [ADDR_W-1:0] wr_a, next_wr_a;
    logic [DATA_W-1:0] wr_d, next_wr_d;
    logic ds_rise, wr_rise, wake_fall;
    logic pend, next_pend;
    logic rst_drv, next_rst_drv;
    logic selected, is_read, end_write;
    logic [ADDR_W-1:0] acc_addr;

    hbp_edge_det u_ds (.clk_i(bus.clk_i), .arst_n_i(bus.arst_n_i),
        .sig_i(bus.access_strobe), .rise_o(ds_rise), .fall_o());
    hbp_edge_det u_wr (.clk_i(bus.clk_i), .arst_n_i(bus.arst_n_i),
        .sig_i(bus.rw_wr), .rise_o(wr_rise), .fall_o());
    hbp_edge_det u_wk (.clk_i(bus.clk_i), .arst_n_i(bus.arst_n_i),
        .sig_i(external_wake_i), .rise_o(), .fall_o(wake_fall));

    always_comb begin
        selected = ~bus.cs_n & ~in_reset;
        acc_addr = muxed ? lat_addr : bus.addr_bit_in;
        if (bus_style_i == STYLE_STROBE_DIR) begin
            is_read = selected & bus.rw_wr & ~bus.access_strobe;
            end_write = selected & ~bus.rw_wr & ds_rise;
        end else begin
            is_read = selected & ~bus.access_strobe;
            end_write = selected & wr_rise;
        end
    end

    always_comb begin
        next_muxed = muxed;
        next_lat_addr = lat_addr;
        if (bus.ale) begin
            next_muxed = 1'b1;
        end
        if (bus.ale && !bus.cs_n) begin
            next_lat_addr = bus.shared_bus_line[ADDR_W-1:0];
        end
        // lat_addr untouched until next latch phase
    end

    always_comb begin
        next_doe = 1'b0;
        next_dout = dout;
        next_wr_p = 1'b0;
        next_wr_a = wr_a;
        next_wr_d = wr_d;
        if (is_read) begin
            next_doe = 1'b1;
            next_dout = regs[acc_addr];
        end
        if (end_write) begin
            next_wr_p = 1'b1;
            next_wr_a = acc_addr;
            next_wr_d = bus.shared_bus_line;
        end
    end

    always_comb begin
        next_rst_in_cnt = rst_in_cnt;
        next_in_reset = in_reset;
        next_rst_out_cnt = rst_out_cnt;
        next_wake_irq = wake_irq;
        next_irq = irq;
        if (bus.rst_line && !(rst_out_cnt != CNT_ZERO)) begin
            if (rst_in_cnt != RST_HOLD_CNT) begin
                next_rst_in_cnt = rst_in_cnt + 10'h001;
            end else begin
                next_in_reset = 1'b1;
            end
        end else begin
            next_rst_in_cnt = CNT_ZERO;
            next_in_reset = bus.rst_line;
        end
        if (rst_out_cnt != CNT_ZERO) begin
            next_rst_out_cnt = rst_out_cnt - 10'h001;
        end
        // wake edge sets interrupt, optional reset
        if (wake_fall && term_fn_en_i) begin
            next_wake_irq = 1'b1;
            if (wake_rst_en_i) begin
                next_rst_out_cnt = RST_OUT_CNT;
            end
        end else if (irq_clr_i) begin
            next_wake_irq = 1'b0;
        end
        // set beats clear
        if (irq_set_i) begin
            next_irq = 1'b1;
        end else if (irq_clr_i) begin
            next_irq = 1'b0;
        end
        // registered from next values so pins carry no gate delay
        next_pend = next_irq | next_wake_irq;
        next_rst_drv = (next_rst_out_cnt != CNT_ZERO);
    end

    always_ff @(posedge bus.clk_i or negedge bus.arst_n_i) begin
        if (!bus.arst_n_i) begin
            muxed <= 1'b0;
            lat_addr <= ADDR_RST;
            doe <= 1'b0;
            dout <= DATA_RST;
            wr_p <= 1'b0;
            wr_a <= ADDR_RST;
            wr_d <= DATA_RST;
            rst_in_cnt <= CNT_ZERO;
            in_reset <= 1'b0;
            rst_out_cnt <= CNT_ZERO;
            wake_irq <= 1'b0;
            irq <= 1'b0;
            pend <= 1'b0;
            rst_drv <= 1'b0;
        end else begin
            muxed <= next_muxed;
            lat_addr <= next_lat_addr;
            doe <= next_doe;
            dout <= next_dout;
            wr_p <= next_wr_p;
            wr_a <= next_wr_a;
            wr_d <= next_wr_d;
            rst_in_cnt <= next_rst_in_cnt;
            in_reset <= next_in_reset;
            rst_out_cnt <= next_rst_out_cnt;
            wake_irq <= next_wake_irq;
            irq <= next_irq;
            pend <= next_pend;
            rst_drv <= next_rst_drv;
        end
    end

    // register array has no reset; contents undefined until written
    always_ff @(posedge bus.clk_i) begin
        if (end_write) begin
            regs[acc_addr] <= bus.shared_bus_line;
        end
    end

    // interrupt pulls low only, never drives high
    assign bus.int_d_oe = pend;
    assign bus.bus_d_out = dout;
    assign bus.bus_d_oe = doe;
    assign bus.rst_d_out = 1'b1;
    assign bus.rst_d_oe = rst_drv;
    assign wr_pulse_o = wr_p;
    assign wr_addr_o = wr_a;
    assign wr_data_o = wr_d;
    assign irq_pend_o = pend;
    assign dev_in_reset_o = in_reset;
endmodule : hbp_device

//--- hbp_host.sv
// Purpose: host end; turns user requests into pin cycles
// Assumes: device registered answers appear one cycle after strobe
// Notes: one access at a time; req ignored while busy
`timescale 1ns/10ps
module hbp_host
    import hbp_pkg::*;
(
    hbp_if.host bus,
    input wire logic muxed_i,
    input wire logic bus_style_i,
    input wire logic req_i,
    input wire logic rd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic rst_req_i,
    output logic busy_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic irq_o
);
    host_state_t st, next_st;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic rd, next_rd;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] wd, next_wd, rdat, next_rdat;
    logic done, next_done, irq, next_irq;
    logic cs_n, next_cs_n, ale, next_ale, rw, next_rw, ds, next_ds;
    logic boe, next_boe, rst, next_rst;
    logic [DATA_W-1:0] bout, next_bout;
    logic [ADDR_W-1:0] aout, next_aout;
    logic busy, next_busy;

    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_rd = rd;
        next_addr = addr;
        next_wd = wd;
        next_rdat = rdat;
        next_done = 1'b0;
        next_irq = ~bus.irq_n;
        next_cs_n = cs_n;
        next_ale = 1'b0;
        next_rw = rw;
        next_ds = ds;
        next_boe = 1'b0;
        next_rst = 1'b0;
        next_bout = bout;
        next_aout = aout;
        case (st)
            H_IDLE: begin
                next_cs_n = 1'b1;
                next_ds = 1'b1;
                // high is read in one style and write strobe off in the other
                next_rw = 1'b1;
                if (rst_req_i) begin
                    next_st = H_RESET;
                    next_cnt = RST_HOLD_CNT;
                    next_rst = 1'b1;
                end else if (req_i) begin
                    next_rd = rd_i;
                    next_addr = addr_i;
                    next_wd = wdata_i;
                    next_cs_n = 1'b0;
                    if (muxed_i) begin
                        next_ale = 1'b1;
                        next_boe = 1'b1;
                        next_bout = {2'b00, addr_i};
                        next_st = H_ADDR;
                    end else begin
                        next_aout = addr_i;
                        next_st = H_SETUP;
                    end
                end
            end
            H_ADDR: begin
                next_st = H_SETUP;
            end
            H_SETUP: begin
                if (bus_style_i == STYLE_STROBE_DIR) begin
                    next_rw = rd;
                    next_ds = 1'b0;
                end else begin
                    next_rw = rd;
                    next_ds = ~rd;
                end
                next_boe = ~rd;
                next_bout = wd;
                next_st = H_STROBE;
            end
            H_STROBE: begin
                next_boe = ~rd;
                next_bout = wd;
                next_ds = 1'b1;
                next_rw = (bus_style_i == STYLE_STROBE_DIR) ? rd : 1'b1;
                next_st = H_END;
            end
            H_END: begin
                next_cs_n = 1'b1;
                next_done = 1'b1;
                // device answer is registered, so it stands one cycle late
                if (rd) begin
                    next_rdat = bus.shared_bus_line;
                end
                next_st = H_IDLE;
            end
            H_RESET: begin
                next_rst = 1'b1;
                if (cnt == CNT_ZERO) begin
                    next_rst = 1'b0;
                    next_st = H_IDLE;
                end else begin
                    next_cnt = cnt - 10'h001;
                end
            end
            default: begin
                next_st = H_IDLE;
            end
        endcase
        next_busy = (next_st != H_IDLE);
    end

    always_ff @(posedge bus.clk_i or negedge bus.arst_n_i) begin
        if (!bus.arst_n_i) begin
            st <= H_IDLE;
            cnt <= CNT_ZERO;
            rd <= 1'b0;
            addr <= ADDR_RST;
            wd <= DATA_RST;
            rdat <= DATA_RST;
            done <= 1'b0;
            irq <= 1'b0;
            cs_n <= 1'b1;
            ale <= 1'b0;
            rw <= 1'b1;
            ds <= 1'b1;
            boe <= 1'b0;
            rst <= 1'b0;
            bout <= DATA_RST;
            aout <= ADDR_RST;
            busy <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            rd <= next_rd;
            addr <= next_addr;
            wd <= next_wd;
            rdat <= next_rdat;
            done <= next_done;
            irq <= next_irq;
            cs_n <= next_cs_n;
            ale <= next_ale;
            rw <= next_rw;
            ds <= next_ds;
            boe <= next_boe;
            rst <= next_rst;
            bout <= next_bout;
            aout <= next_aout;
            busy <= next_busy;
        end
    end

    assign bus.cs_n = cs_n;
    assign bus.ale = ale;
    assign bus.rw_wr = rw;
    assign bus.access_strobe = ds;
    assign bus.bus_h_out = bout;
    assign bus.bus_h_oe = boe;
    assign bus.addr_bit_in = aout;
    assign bus.rst_h_out = 1'b1;
    assign bus.rst_h_oe = rst;
    assign busy_o = busy;
    assign done_o = done;
    assign rdata_o = rdat;
    assign irq_o = irq;
endmodule : hbp_host

//--- hbp_assertions.sv
// Purpose: checks on the pins between host end and device end
// Assumes: one clock; reset low active
// Notes: sees interface signals only, no user side
`timescale 1ns/10ps
module hbp_assertions
    import hbp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic bus_h_oe,
    input wire logic bus_d_oe,
    input wire logic cs_n,
    input wire logic ale,
    input wire logic rw_wr,
    input wire logic access_strobe,
    input wire logic irq_n,
    input wire logic rst_line
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // counts reset-line high time; hundreds of cycles, too long for a repetition
    logic [15:0] hi_cnt;
    logic [15:0] next_hi_cnt;
    always_comb begin
        next_hi_cnt = rst_line ? hi_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt <= 16'h0000;
        end else begin
            hi_cnt <= next_hi_cnt;
        end
    end
    chk_oe_select: assert property (
        bus_d_oe |-> (!cs_n || !$past(cs_n))) else $error("device drives while unselected");
    chk_oe_strobe: assert property (
        bus_d_oe |-> (!access_strobe || !$past(access_strobe))) else $error("drive without strobe");
    chk_oe_read_only: assert property (
        bus_d_oe |-> (rw_wr || $past(rw_wr))) else $error("device drives during write");
    chk_no_contention: assert property (
        !(bus_d_oe && bus_h_oe)) else $error("both ends drive shared lines");
    chk_read_answer: assert property (
        (!cs_n && !access_strobe && rw_wr && !rst_line) |=> bus_d_oe) else $error("no read answer");
    chk_addr_phase: assert property (
        ale |-> (!cs_n && bus_h_oe && access_strobe && rw_wr)) else $error("bad address phase");
    chk_ale_single: assert property (
        ale |=> !ale) else $error("address latch longer than one cycle");
    chk_strobe_select: assert property (
        !access_strobe |-> !cs_n) else $error("strobe without chip select");
    chk_rst_length: assert property (
        $fell(rst_line) |-> hi_cnt >= RST_HOLD_CYC) else $error("reset pulse too short");
    cover property (ale);
    cover property (bus_d_oe);
    cover property ($fell(irq_n));
    cover property ($rose(rst_line));
endmodule : hbp_assertions

//--- isdn_ctrl_host_bus_port_tb.sv
// Purpose: host end against device end, driven from both user sides
// Assumes: 50 MHz clock, reset held 20 cycles
// Notes: muxed mode is sticky, so the muxed scenario runs last
`timescale 1ns/10ps
module isdn_ctrl_host_bus_port_tb
    import hbp_pkg::*;
;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic muxed, style, req, rd, rst_req, term_en, wake_rst_en, ext_wake, irq_set, irq_clr;
    logic [ADDR_W-1:0] addr, wr_addr;
    logic [DATA_W-1:0] wdata, wr_data, rdata;
    logic wr_pulse, irq_pend, dev_rst, busy, done, irq;
    int error_cnt = 0;
    int cmp_count = 0;

    always #10 clk_i = ~clk_i;

    hbp_if i_hbp_if (.clk_i(clk_i), .arst_n_i(arst_n_i));
    hbp_device i_hbp_device (.bus(i_hbp_if), .bus_style_i(style), .term_fn_en_i(term_en),
        .wake_rst_en_i(wake_rst_en), .external_wake_i(ext_wake), .irq_set_i(irq_set),
        .irq_clr_i(irq_clr), .wr_pulse_o(wr_pulse), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .irq_pend_o(irq_pend), .dev_in_reset_o(dev_rst));
    hbp_host i_hbp_host (.bus(i_hbp_if), .muxed_i(muxed), .bus_style_i(style), .req_i(req),
        .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .rst_req_i(rst_req), .busy_o(busy),
        .done_o(done), .rdata_o(rdata), .irq_o(irq));
    hbp_assertions i_hbp_assertions (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .bus_h_oe(i_hbp_if.bus_h_oe), .bus_d_oe(i_hbp_if.bus_d_oe), .cs_n(i_hbp_if.cs_n),
        .ale(i_hbp_if.ale), .rw_wr(i_hbp_if.rw_wr), .access_strobe(i_hbp_if.access_strobe),
        .irq_n(i_hbp_if.irq_n), .rst_line(i_hbp_if.rst_line));

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic timeout_end;
        error_cnt++;
        $display("MISMATCH t=%0t got=%h exp=%h wait limit ran out", $time, 1'b0, 1'b1);
        conclude();
    endtask : timeout_end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // one access; write checked at the user side of the device end
    task automatic xfer(input logic r, input logic [5:0] a, input logic [7:0] d,
                        input logic [7:0] lat);
        int n;
        int got;
        logic seen;
        logic [7:0] wa;
        logic [7:0] wd;
        got = 0;
        seen = 1'b0;
        wa = 8'h00;
        wd = 8'h00;
        @(posedge clk_i);
        req <= 1'b1;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        req <= 1'b0;
        // write pulse may trail done, so look a few cycles on
        // n counts cycles from the one in which req is presented
        for (n = 2; n < 25 && (got == 0 || n <= got + 3); n++) begin
            @(posedge clk_i);
            #1;
            if (n == 2) chk1(busy, 1'b1);
            if (done === 1'b1 && got == 0) got = n;
            if (wr_pulse === 1'b1) begin
                seen = 1'b1;
                wa = {2'b00, wr_addr};
                wd = wr_data;
            end
        end
        if (got == 0) timeout_end();
        chk1(busy, 1'b0);
        chk8(8'(got), lat);
        if (r) chk8(rdata, d);
        else begin
            chk1(seen, 1'b1);
            chk8(wa, {2'b00, a});
            chk8(wd, d);
        end
    endtask : xfer

    task automatic pulse(input logic s, input logic c);
        @(posedge clk_i);
        irq_set <= s;
        irq_clr <= c;
        @(posedge clk_i);
        irq_set <= 1'b0;
        irq_clr <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : pulse

    // measures a reset pulse on the shared reset line
    task automatic rst_watch;
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (i_hbp_if.rst_line !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (i_hbp_if.rst_line !== 1'b1) timeout_end();
        n = 0;
        while (i_hbp_if.rst_line === 1'b1 && n < 6000) begin
            @(posedge clk_i);
            #1;
            n++;
            if (dev_rst === 1'b1) seen = 1'b1;
        end
        for (int k = 0; k < 20; k++) begin
            @(posedge clk_i);
            #1;
            if (dev_rst === 1'b1) seen = 1'b1;
        end
        chk1(n >= RST_HOLD_CYC && n < 6000, 1'b1);
        chk1(seen, 1'b1);
        chk1(dev_rst, 1'b0);
    endtask : rst_watch

    task automatic s_plain;
        xfer(1'b0, 6'h05, 8'ha5, 8'h04);
        xfer(1'b0, 6'h3f, 8'h5a, 8'h04);
        xfer(1'b1, 6'h05, 8'ha5, 8'h04);
        xfer(1'b1, 6'h3f, 8'h5a, 8'h04);
    endtask : s_plain

    task automatic s_split;
        @(posedge clk_i);
        style <= 1'b1;
        xfer(1'b0, 6'h00, 8'hc3, 8'h04);
        xfer(1'b1, 6'h00, 8'hc3, 8'h04);
        xfer(1'b1, 6'h3f, 8'h5a, 8'h04);
    endtask : s_split

    task automatic s_irq;
        pulse(1'b1, 1'b0);
        chk1(i_hbp_if.irq_n, 1'b0);
        chk1(irq, 1'b1);
        pulse(1'b1, 1'b1);
        chk1(irq_pend, 1'b1);
        pulse(1'b0, 1'b1);
        chk1(i_hbp_if.irq_n, 1'b1);
        chk1(irq, 1'b0);
    endtask : s_irq

    task automatic s_wake;
        @(posedge clk_i);
        term_en <= 1'b1;
        wake_rst_en <= 1'b1;
        @(posedge clk_i);
        ext_wake <= 1'b0;
        // watch from the fall, so the whole self-driven pulse is counted
        rst_watch();
        chk1(irq_pend, 1'b1);
        @(posedge clk_i);
        ext_wake <= 1'b1;
        pulse(1'b0, 1'b1);
        chk1(irq_pend, 1'b0);
    endtask : s_wake

    task automatic s_hostrst;
        @(posedge clk_i);
        rst_req <= 1'b1;
        @(posedge clk_i);
        rst_req <= 1'b0;
        rst_watch();
    endtask : s_hostrst

    // back-to-back muxed accesses in both bus styles, including a read-back of one address
    task automatic s_mux;
        @(posedge clk_i);
        muxed <= 1'b1;
        style <= 1'b0;
        xfer(1'b0, 6'h2a, 8'h3c, 8'h05);
        xfer(1'b1, 6'h2a, 8'h3c, 8'h05);
        @(posedge clk_i);
        style <= 1'b1;
        xfer(1'b1, 6'h05, 8'ha5, 8'h05);
        xfer(1'b0, 6'h11, 8'h96, 8'h05);
    endtask : s_mux

    initial begin
        {muxed, style, req, rd, rst_req, term_en, wake_rst_en, irq_set, irq_clr} = 9'h000;
        ext_wake = 1'b1;
        addr = 6'h00;
        wdata = 8'h00;
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk8(i_hbp_if.shared_bus_line, 8'hff);
        s_plain();
        s_split();
        s_irq();
        s_wake();
        s_hostrst();
        s_mux();
        conclude();
    end
endmodule : isdn_ctrl_host_bus_port_tb
